// File: rtl/asi_display_defines.vh
// Constants for the AS-i master display and operating-mode controller.
// Assumes a 250 MHz module clock and a byte-addressed register port.
`ifndef ASI_DISPLAY_DEFINES_VH
`define ASI_DISPLAY_DEFINES_VH

// Register byte addresses.
`define REG_CTRL 8'h00
`define REG_FALLBACK 8'h04
`define REG_EXPECTED 8'h08
`define REG_DETECTED 8'h0C
`define REG_ACTIVE 8'h10
`define REG_OUT_DATA 8'h14
`define REG_STATUS 8'h18
`define REG_IN_DATA 8'h1C

// Control and fallback register fields and reset values.
`define CTRL_RUN_BIT 0
`define CTRL_AUTO_BIT 1
`define CTRL_CFG_BIT 2
`define CTRL_RUN_RESET 1'b1
`define CTRL_AUTO_RESET 1'b0
`define FALLBACK_RESET 16'h0001
`define FALLBACK_SELECT_BIT 0

// Status register: sticky duplicate-address error bit, cleared by writing one.
`define STATUS_DUP_BIT 15

// Out-data register: slave address field and data field.
`define OUT_ADDR_LSB 8
`define OUT_ADDR_MSB 12

// Timing, in milliseconds, and the clock rate in kHz.
`define CLK_KHZ 28'h3D090
`define DEBOUNCE_MS 28'h14
`define LONG_PRESS_MS 28'h320
`define FLASH_HALF_MS 28'hFA

`endif

// File: rtl/asi_master_display_and_mode_ctrl.v
// Front-panel display navigation and operating-mode control of an AS-i bus master.
// Assumes a same-clock bus engine reporting slave scans, and button, supply-fault and medium-cut pins arriving asynchronously.
// Notes on behaviour
// R1: Long scroll press in bus view enters address view, address 1 to 31.
// R2: Short plus press steps selected address by one in the scan direction.
// R3: Address view keeps both bus and I/O mode lamps off.
// R4: Long plus press in address view shows the selected slave's I/O bits.
// R5: I/O view lamps 0 to 3 show the four input bits.
// R6: I/O view lamps 4 to 7 show the four output bits.
// R7: I/O view lights the I/O mode lamp, bus mode lamp off.
// R8: Short scroll press in address view toggles scan direction.
// R9: Fallback word bit 0: one forces outputs to zero, zero holds them.
// R10: STOP with zero fallback forces outputs to zero, then stops the bus.
// R11: STOP with hold fallback keeps outputs, then stops the bus.
// R12: Automatic replacement only when enabled, without stopping the bus.
// R13: Replacement at the missing address with right profile rejoins both lists.
// R14: Matching slave at address 0 gets the missing address, then joins lists.
// R15: Address or profile mismatch flashes error and AS-i lamps together.
// R16: Replacement only when exactly one configured slave is faulty.
// R17: Loss of the processor link puts the module in its safe state; the code ignores it in ST_WAIT.
// R18: Serious internal fault stops backplane and AS-i communication.
// R19: After power-up stay stopped until configuration or a button press.
// R20: Supply fault stops the bus and lights the AS-i lamp steadily.
// R21: Medium cut at the output acts as supply fault; all slaves disappear.
// R22: Transmission errors from duplicate addresses are flagged.
// R23: Bus view is the power-up default; lamps 1 to 31 are addresses.
// R24: Bus lamp steady if expected and detected, flashing if one, else off.
// R25: Bus view lights the bus mode lamp, I/O mode lamp off.
// R26: Buttons are debounced and held time separates short from long presses.
`timescale 1ns/1ps
`include "asi_display_defines.vh"

module asi_master_display_and_mode_ctrl #(
   parameter [27:0] DEBOUNCE_CYC = `DEBOUNCE_MS * `CLK_KHZ,
   parameter [27:0] LONG_CYC = `LONG_PRESS_MS * `CLK_KHZ,
   parameter [27:0] FLASH_CYC = `FLASH_HALF_MS * `CLK_KHZ
) (
   input wire clk,
   input wire rst,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   input wire press_scroll,
   input wire press_plus,
   input wire supply_fault,
   input wire medium_cut,
   input wire proc_link_lost,
   input wire internal_fault,
   input wire rsp_valid,
   input wire [4:0] rsp_addr,
   input wire rsp_present,
   input wire rsp_profile_ok,
   input wire [3:0] rsp_in_bits,
   input wire rsp_tx_error,
   input wire out_cycle_done,
   input wire readdr_done,
   input wire [4:0] out_poll_addr,
   output reg [3:0] out_bits,
   output reg readdr_req,
   output reg [4:0] readdr_addr,
   output reg bus_enable,
   output reg backplane_enable,
   output reg [31:0] lamp,
   output reg lamp_bus,
   output reg lamp_io,
   output reg lamp_err,
   output reg lamp_asi
);

   localparam [2:0] ST_WAIT = 3'd0;
   localparam [2:0] ST_RUN = 3'd1;
   localparam [2:0] ST_FALL = 3'd2;
   localparam [2:0] ST_STOP = 3'd3;
   localparam [2:0] ST_SAFE = 3'd4;
   localparam [2:0] ST_FAULT = 3'd5;
   localparam [1:0] VIEW_BUS = 2'd0;
   localparam [1:0] VIEW_ADDR = 2'd1;
   localparam [1:0] VIEW_IO = 2'd2;
   localparam B_SCROLL = 0;
   localparam B_PLUS = 1;

   function one_hot;
      input [31:0] v;
      begin
         one_hot = (v != 32'h0) && ((v & (v - 32'h1)) == 32'h0);
      end
   endfunction

   function [4:0] lowest_index;
      input [31:0] v;
      integer k;
      begin
         lowest_index = 5'h0;
         for (k = 31; k >= 0; k = k - 1) begin
            if (v[k]) begin
               lowest_index = k[4:0];
            end
         end
      end
   endfunction

   reg [1:0] btn_s1, btn_s2, btn_stable, short_p, long_p;
   reg [27:0] deb_cnt [0:1];
   reg [27:0] hold_cnt [0:1];
   reg sup_s1, sup_s2, cut_s1, cut_s2;
   reg [2:0] state;
   reg [1:0] view;
   reg [4:0] sel;
   reg scan_up;
   reg run_req, auto_en;
   reg [15:0] fallback_config_word;
   reg [31:0] expected, detected, active, lost;
   reg [3:0] in_img [0:31];
   reg [3:0] out_img [0:31];
   reg [4:0] io_idx;
   reg readdr_busy, mismatch, dup_err, fall_wrap;
   reg [27:0] flash_cnt;
   reg flash_phase;
   integer i;

   wire supply_bad = sup_s2 | cut_s2;
   wire cfg_load = wr && (addr == `REG_CTRL) && wdata[`CTRL_CFG_BIT];
   wire zero_fallback = fallback_config_word[`FALLBACK_SELECT_BIT];
   wire single_lost = one_hot(lost);
   wire any_press = short_p != 2'b00 || long_p != 2'b00;

   // Button, supply-fault and medium-cut pins pass two flip-flops before anything reads them.
   always @(posedge clk) begin
      if (rst) begin
         btn_s1 <= 2'b00;
         btn_s2 <= 2'b00;
         sup_s1 <= 1'b0;
         sup_s2 <= 1'b0;
         cut_s1 <= 1'b0;
         cut_s2 <= 1'b0;
      end else begin
         btn_s1 <= {press_plus, press_scroll};
         btn_s2 <= btn_s1;
         sup_s1 <= supply_fault;
         sup_s2 <= sup_s1;
         cut_s1 <= medium_cut;
         cut_s2 <= cut_s1;
      end
   end

   // A long press fires while the button is still held, so the release that
   // follows it must not also count as a short press.
   always @(posedge clk) begin
      if (rst) begin
         btn_stable <= 2'b00;
         short_p <= 2'b00;
         long_p <= 2'b00;
         for (i = 0; i < 2; i = i + 1) begin
            deb_cnt[i] <= 28'h0;
            hold_cnt[i] <= 28'h0;
         end
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            short_p[i] <= 1'b0;
            long_p[i] <= 1'b0;
            if (btn_s2[i] != btn_stable[i]) begin
               if (deb_cnt[i] >= DEBOUNCE_CYC - 28'h1) begin
                  btn_stable[i] <= btn_s2[i]; // R26
                  deb_cnt[i] <= 28'h0;
               end else begin
                  deb_cnt[i] <= deb_cnt[i] + 28'h1;
               end
            end else begin
               deb_cnt[i] <= 28'h0;
            end
            if (btn_stable[i]) begin
               if (hold_cnt[i] != LONG_CYC) begin
                  hold_cnt[i] <= hold_cnt[i] + 28'h1;
               end
               if (hold_cnt[i] == LONG_CYC - 28'h1) begin
                  long_p[i] <= 1'b1; // R26
               end
            end else begin
               if (hold_cnt[i] != 28'h0 && hold_cnt[i] < LONG_CYC) begin
                  short_p[i] <= 1'b1; // R26
               end
               hold_cnt[i] <= 28'h0;
            end
         end
      end
   end

   // View navigation.
   always @(posedge clk) begin
      if (rst) begin
         view <= VIEW_BUS; // R23
         sel <= 5'd1;
         scan_up <= 1'b1;
      end else begin
         case (view)
            VIEW_BUS: begin
               if (long_p[B_SCROLL]) begin
                  view <= VIEW_ADDR; // R1
               end
            end
            VIEW_ADDR: begin
               if (long_p[B_SCROLL]) begin
                  view <= VIEW_BUS;
               end else if (long_p[B_PLUS]) begin
                  view <= VIEW_IO; // R4
               end else if (short_p[B_SCROLL]) begin
                  scan_up <= ~scan_up; // R8
               end else if (short_p[B_PLUS]) begin
                  if (scan_up) begin
                     sel <= (sel == 5'd31) ? 5'd1 : sel + 5'd1; // R2
                  end else begin
                     sel <= (sel == 5'd1) ? 5'd31 : sel - 5'd1; // R2
                  end
               end
            end
            VIEW_IO: begin
               if (long_p[B_SCROLL]) begin
                  view <= VIEW_BUS;
               end else if (long_p[B_PLUS]) begin
                  view <= VIEW_ADDR;
               end
            end
            default: view <= VIEW_BUS;
         endcase
      end
   end

   // Operating mode.
   always @(posedge clk) begin
      if (rst) begin
         state <= ST_WAIT;
      end else if (internal_fault) begin
         state <= ST_FAULT; // R18
      end else begin
         case (state)
            ST_WAIT: begin
               if (cfg_load || any_press) begin
                  state <= ST_RUN; // R19
               end
            end
            ST_RUN: begin
               if (proc_link_lost) begin
                  state <= ST_SAFE; // R17
               end else if (!run_req) begin
                  state <= zero_fallback ? ST_FALL : ST_STOP; // R10 R11
               end
            end
            ST_FALL: begin
               if (proc_link_lost) begin
                  state <= ST_SAFE; // R17
               end else if (out_cycle_done && fall_wrap) begin
                  state <= ST_STOP; // R10
               end
            end
            ST_STOP: begin
               if (proc_link_lost) begin
                  state <= ST_SAFE; // R17
               end else if (run_req) begin
                  state <= ST_RUN;
               end
            end
            ST_SAFE: begin
               if (cfg_load && !proc_link_lost) begin
                  state <= ST_RUN;
               end
            end
            ST_FAULT: state <= ST_FAULT;
            default: state <= ST_WAIT;
         endcase
      end
   end

   // Zeros must fill one whole bus cycle; the first done pulse may close a cycle begun before them.
   always @(posedge clk) fall_wrap <= !rst && state == ST_FALL && (fall_wrap || out_cycle_done); // R10

   // Software registers.
   always @(posedge clk) begin
      if (rst) begin
         run_req <= `CTRL_RUN_RESET;
         auto_en <= `CTRL_AUTO_RESET;
         fallback_config_word <= `FALLBACK_RESET;
         expected <= 32'h0;
         io_idx <= 5'h0;
      end else if (wr) begin
         case (addr)
            `REG_CTRL: begin
               run_req <= wdata[`CTRL_RUN_BIT];
               auto_en <= wdata[`CTRL_AUTO_BIT]; // R12
            end
            `REG_FALLBACK: fallback_config_word <= wdata[15:0]; // R9
            `REG_EXPECTED: expected <= {wdata[31:1], 1'b0};
            `REG_OUT_DATA: io_idx <= wdata[`OUT_ADDR_MSB:`OUT_ADDR_LSB];
            default: io_idx <= io_idx;
         endcase
      end
   end

   always @(posedge clk) begin
      if (wr && addr == `REG_OUT_DATA) begin
         out_img[wdata[`OUT_ADDR_MSB:`OUT_ADDR_LSB]] <= wdata[3:0];
      end
      if (rsp_valid && rsp_present) begin
         in_img[rsp_addr] <= rsp_in_bits;
      end
   end

   // Slave lists and automatic replacement; a lost slave is one that was active.
   always @(posedge clk) begin
      if (rst) begin
         detected <= 32'h0;
         active <= 32'h0;
         lost <= 32'h0;
         readdr_req <= 1'b0;
         readdr_addr <= 5'h0;
         readdr_busy <= 1'b0;
      end else begin
         readdr_req <= 1'b0;
         if (supply_bad) begin
            detected <= 32'h0; // R21
            active <= 32'h0; // R21
         end else if (readdr_busy && readdr_done) begin
            detected[readdr_addr] <= 1'b1; // R14
            active[readdr_addr] <= 1'b1; // R14
            lost[readdr_addr] <= 1'b0;
            readdr_busy <= 1'b0;
         end else if (rsp_valid && rsp_addr != 5'h0) begin
            if (!rsp_present) begin
               detected[rsp_addr] <= 1'b0;
               active[rsp_addr] <= 1'b0;
               if (active[rsp_addr]) begin
                  lost[rsp_addr] <= 1'b1;
               end
            end else if (!lost[rsp_addr]) begin
               detected[rsp_addr] <= 1'b1;
               active[rsp_addr] <= expected[rsp_addr] & rsp_profile_ok;
            end else begin
               detected[rsp_addr] <= 1'b1;
               if (auto_en && single_lost && rsp_profile_ok) begin // R12 R16
                  active[rsp_addr] <= 1'b1; // R13
                  lost[rsp_addr] <= 1'b0; // R13
               end
            end
         end else if (rsp_valid && rsp_present && rsp_profile_ok && auto_en && single_lost && !readdr_busy) begin
            readdr_req <= 1'b1; // R14
            readdr_addr <= lowest_index(lost); // R14
            readdr_busy <= 1'b1;
         end
         if (wr && addr == `REG_EXPECTED) begin
            lost <= 32'h0;
         end
      end
   end

   // Sticky flags: a new event in the clearing cycle wins.
   always @(posedge clk) begin
      if (rst) begin
         mismatch <= 1'b0;
         dup_err <= 1'b0;
      end else begin
         if (auto_en && rsp_valid && rsp_present && lost != 32'h0 && (rsp_addr == 5'h0 || lost[rsp_addr])
             && !(rsp_profile_ok && single_lost)) begin
            mismatch <= 1'b1; // R15
         end else if (lost == 32'h0) begin
            mismatch <= 1'b0;
         end
         if (rsp_valid && rsp_tx_error) begin
            dup_err <= 1'b1; // R22
         end else if (wr && addr == `REG_STATUS && wdata[`STATUS_DUP_BIT]) begin
            dup_err <= 1'b0;
         end
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         flash_cnt <= 28'h0;
         flash_phase <= 1'b0;
      end else if (flash_cnt >= FLASH_CYC - 28'h1) begin
         flash_cnt <= 28'h0;
         flash_phase <= ~flash_phase;
      end else begin
         flash_cnt <= flash_cnt + 28'h1;
      end
   end

   // Outputs to the bus engine, the backplane and the lamps.
   always @(posedge clk) begin
      if (rst) begin
         out_bits <= 4'h0;
         bus_enable <= 1'b0;
         backplane_enable <= 1'b0;
         lamp <= 32'h0;
         lamp_bus <= 1'b1;
         lamp_io <= 1'b0;
         lamp_err <= 1'b0;
         lamp_asi <= 1'b0;
      end else begin
         if (state == ST_FALL || (state == ST_SAFE && zero_fallback)) begin
            out_bits <= 4'h0; // R10
         end else begin
            out_bits <= out_img[out_poll_addr]; // R11
         end
         bus_enable <= (state == ST_RUN || state == ST_FALL) && !supply_bad; // R10 R11 R20
         backplane_enable <= state != ST_FAULT; // R18
         lamp <= 32'h0;
         case (view)
            VIEW_ADDR: begin
               lamp[sel] <= 1'b1; // R1
               lamp_bus <= 1'b0; // R3
               lamp_io <= 1'b0; // R3
            end
            VIEW_IO: begin
               lamp[3:0] <= in_img[sel]; // R5
               lamp[7:4] <= out_img[sel]; // R6
               lamp_bus <= 1'b0; // R7
               lamp_io <= 1'b1; // R7
            end
            default: begin
               lamp <= ((expected & detected) | ((expected ^ detected) & {32{flash_phase}})) & 32'hFFFFFFFE; // R24
               lamp_bus <= 1'b1; // R25
               lamp_io <= 1'b0; // R25
            end
         endcase
         lamp_err <= (mismatch && flash_phase) || state == ST_FAULT; // R15
         lamp_asi <= supply_bad || (mismatch && flash_phase); // R15 R20
      end
   end

   // Read data stand only in the cycle after the strobe.
   always @(posedge clk) begin
      if (rst || !rd) begin
         rdata <= 32'h0;
      end else begin
         case (addr)
            `REG_CTRL: rdata <= {30'h0, auto_en, run_req};
            `REG_FALLBACK: rdata <= {16'h0, fallback_config_word};
            `REG_EXPECTED: rdata <= expected;
            `REG_DETECTED: rdata <= detected;
            `REG_ACTIVE: rdata <= active;
            `REG_OUT_DATA: rdata <= {19'h0, io_idx, 4'h0, out_img[io_idx]};
            `REG_STATUS: rdata <= {18'h0, dup_err, mismatch, supply_bad, scan_up, view, sel, state};
            `REG_IN_DATA: rdata <= {28'h0, in_img[io_idx]};
            default: rdata <= 32'h0;
         endcase
      end
   end

endmodule

// File: bench/asi_display_monitor.sv
// Port checks for the display and mode controller.
// Assumes one clock and the controller's synchronous active-high reset.
`timescale 1ns/1ps
module asi_display_monitor (
   input wire clk,
   input wire rst,
   input wire rd,
   input wire [31:0] rdata,
   input wire supply_fault,
   input wire medium_cut,
   input wire proc_link_lost,
   input wire internal_fault,
   input wire rsp_valid,
   input wire [4:0] rsp_addr,
   input wire rsp_present,
   input wire rsp_profile_ok,
   input wire readdr_req,
   input wire [4:0] readdr_addr,
   input wire bus_enable,
   input wire backplane_enable,
   input wire [31:0] lamp,
   input wire lamp_bus,
   input wire lamp_io,
   input wire lamp_asi
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_rd_idle; !$past(rd) |-> rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
   property p_bus_view; lamp_bus |-> !lamp_io; endproperty
   a_bus_view: assert property (p_bus_view) else $error("both mode lamps lit");
   property p_io_lamps; lamp_io |-> lamp[31:8] == 24'h0; endproperty
   a_io_lamps: assert property (p_io_lamps) else $error("lamp above 7 lit in io view");
   // Only the address view darkens both mode lamps, and it shows one address.
   property p_addr_view; (!lamp_bus && !lamp_io) |-> $onehot(lamp) && !lamp[0]; endproperty
   a_addr_view: assert property (p_addr_view) else $error("address view not one address");
   property p_supply; supply_fault [*6] |-> !bus_enable && lamp_asi; endproperty
   a_supply: assert property (p_supply) else $error("bus runs on supply fault");
   property p_medium; medium_cut [*6] |-> !bus_enable; endproperty
   a_medium: assert property (p_medium) else $error("bus runs with medium cut");
   property p_link; proc_link_lost [*3] |-> !bus_enable; endproperty
   a_link: assert property (p_link) else $error("bus runs without processor");
   property p_fault; internal_fault |-> ##[1:3] (!bus_enable && !backplane_enable); endproperty
   a_fault: assert property (p_fault) else $error("link active after fault");
   property p_readdr; readdr_req |-> readdr_addr != 5'h00 ##1 !readdr_req; endproperty
   a_readdr: assert property (p_readdr) else $error("bad readdress request");
   property p_readdr_cause;
      $rose(readdr_req) |-> $past(rsp_valid) && $past(rsp_addr) == 5'h00
         && $past(rsp_present) && $past(rsp_profile_ok);
   endproperty
   a_readdr_cause: assert property (p_readdr_cause) else $error("readdress without new slave");
   c_readdr: cover property (readdr_req);
   c_io: cover property (lamp_io);
   c_stop: cover property ($fell(bus_enable));
endmodule

bind asi_master_display_and_mode_ctrl asi_display_monitor u_mon (.clk(clk), .rst(rst), .rd(rd), .rdata(rdata),
   .supply_fault(supply_fault), .medium_cut(medium_cut), .proc_link_lost(proc_link_lost),
   .internal_fault(internal_fault), .rsp_valid(rsp_valid), .rsp_addr(rsp_addr), .rsp_present(rsp_present),
   .rsp_profile_ok(rsp_profile_ok), .readdr_req(readdr_req), .readdr_addr(readdr_addr),
   .bus_enable(bus_enable), .backplane_enable(backplane_enable), .lamp(lamp), .lamp_bus(lamp_bus),
   .lamp_io(lamp_io), .lamp_asi(lamp_asi));

// File: bench/asi_slave_bus.sv
// Behavioural slave population behind a simple scanning engine.
// Assumes the controller's clock; the bench edits the slave tables directly.
`timescale 1ns/1ps
module asi_slave_bus (
   input wire clk,
   input wire rst,
   input wire bus_enable,
   input wire [3:0] out_bits,
   input wire readdr_req,
   input wire [4:0] readdr_addr,
   output reg rsp_valid = 1'b0,
   output reg [4:0] rsp_addr = 5'h00,
   output reg rsp_present = 1'b0,
   output reg rsp_profile_ok = 1'b0,
   output reg [3:0] rsp_in_bits = 4'h0,
   output wire rsp_tx_error,
   output reg out_cycle_done = 1'b0,
   output reg readdr_done = 1'b0,
   output reg [4:0] out_poll_addr = 5'h00
);
   logic [31:0] present = 32'h0;
   logic [31:0] prof_ok = 32'hFFFFFFFF;
   logic [3:0] in_img [32];
   logic [3:0] out_img [32];
   logic [5:0] cnt = 6'h00;
   logic [4:0] prev_poll = 5'h00;
   logic [1:0] busy = 2'h0;
   logic tx_err = 1'b0;
   assign rsp_tx_error = tx_err;
   initial for (int i = 0; i < 32; i++) in_img[i] = 4'h0;
   always @(posedge clk) begin
      rsp_valid <= 1'b0;
      out_cycle_done <= 1'b0;
      readdr_done <= 1'b0;
      prev_poll <= out_poll_addr;
      // Only outputs really sent on a running bus reach the slaves.
      if (bus_enable) out_img[prev_poll] <= out_bits;
      if (rst) begin
         cnt <= 6'h00;
         busy <= 2'h0;
      end else begin
         if (bus_enable) begin
            cnt <= cnt + 6'h01;
            out_poll_addr <= cnt[5:1];
            out_cycle_done <= (cnt == 6'h3F);
            if (!cnt[0]) begin
               rsp_valid <= 1'b1;
               rsp_addr <= cnt[5:1];
               rsp_present <= present[cnt[5:1]];
               rsp_profile_ok <= prof_ok[cnt[5:1]];
               rsp_in_bits <= in_img[cnt[5:1]];
            end
         end
         if (readdr_req) busy <= 2'h3;
         else if (busy != 2'h0) begin
            busy <= busy - 2'h1;
            if (busy == 2'h1) begin
               readdr_done <= 1'b1;
               present[0] <= 1'b0;
               present[readdr_addr] <= 1'b1;
            end
         end
      end
   end
endmodule

// File: bench/tb.sv
// Self-checking bench for the display and mode controller.
// Assumes the slave model and shortened timing counts.
`timescale 1ns/1ps
`include "asi_display_defines.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, press_scroll = 1'b0, press_plus = 1'b0;
   logic supply_fault = 1'b0, medium_cut = 1'b0, proc_link_lost = 1'b0, internal_fault = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   wire [31:0] rdata, lamp;
   wire [4:0] rsp_addr, out_poll_addr, readdr_addr;
   wire [3:0] rsp_in_bits, out_bits;
   wire rsp_valid, rsp_present, rsp_profile_ok, rsp_tx_error, out_cycle_done, readdr_done, readdr_req;
   wire bus_enable, backplane_enable, lamp_bus, lamp_io, lamp_err, lamp_asi;
   int errors = 0, compares = 0, n1, n2, ne, nq;
   asi_master_display_and_mode_ctrl #(.DEBOUNCE_CYC(28'd4), .LONG_CYC(28'd20), .FLASH_CYC(28'd8)) u_dut (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .press_scroll(press_scroll), .press_plus(press_plus), .supply_fault(supply_fault), .medium_cut(medium_cut),
      .proc_link_lost(proc_link_lost), .internal_fault(internal_fault), .rsp_valid(rsp_valid),
      .rsp_addr(rsp_addr), .rsp_present(rsp_present), .rsp_profile_ok(rsp_profile_ok),
      .rsp_in_bits(rsp_in_bits), .rsp_tx_error(rsp_tx_error), .out_cycle_done(out_cycle_done),
      .readdr_done(readdr_done), .out_poll_addr(out_poll_addr), .out_bits(out_bits), .readdr_req(readdr_req),
      .readdr_addr(readdr_addr), .bus_enable(bus_enable), .backplane_enable(backplane_enable), .lamp(lamp),
      .lamp_bus(lamp_bus), .lamp_io(lamp_io), .lamp_err(lamp_err), .lamp_asi(lamp_asi));
   asi_slave_bus u_bus (.clk(clk), .rst(rst), .bus_enable(bus_enable), .out_bits(out_bits),
      .readdr_req(readdr_req), .readdr_addr(readdr_addr), .rsp_valid(rsp_valid), .rsp_addr(rsp_addr),
      .rsp_present(rsp_present), .rsp_profile_ok(rsp_profile_ok), .rsp_in_bits(rsp_in_bits),
      .rsp_tx_error(rsp_tx_error), .out_cycle_done(out_cycle_done), .readdr_done(readdr_done),
      .out_poll_addr(out_poll_addr));
   initial forever #2 clk = ~clk;
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic reg_wr(input [7:0] a, input [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input [7:0] a, input [31:0] m, input [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(rdata & m, e)
   endtask
   task automatic press(input s, input lng);
      @(posedge clk);
      {press_scroll, press_plus} <= {s, !s};
      repeat (lng ? 40 : 12) @(posedge clk);
      {press_scroll, press_plus} <= 2'b00;
      cyc(20);
   endtask
   // Counts lamp states over three flash half periods.
   task automatic watch;
      {n1, n2, ne, nq} = '0;
      repeat (24) begin
         cyc(1);
         n1 += lamp[1];
         n2 += lamp[2];
         ne += lamp_err;
         nq += (lamp_err === lamp_asi);
      end
   endtask
   task automatic test_done;
      if (errors == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      test_done;
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      cyc(3);
      rd_chk(`REG_CTRL, 32'hFFFFFFFF, 32'h1);
      rd_chk(`REG_FALLBACK, 32'hFFFF, 32'h1);
      rd_chk(8'h20, 32'hFFFFFFFF, 32'h0);
      rd_chk(`REG_STATUS, 32'h7FF, 32'h408);
      `CHK({bus_enable, lamp_bus, lamp_io}, 3'b010)
      u_bus.in_img[1] = 4'h5;
      u_bus.present = 32'hA;
      reg_wr(`REG_EXPECTED, 32'h6);
      reg_wr(`REG_CTRL, 32'h5);
      cyc(4);
      `CHK(bus_enable, 1'b1)
      cyc(140);
      rd_chk(`REG_DETECTED, 32'hFFFFFFFE, 32'hA);
      rd_chk(`REG_ACTIVE, 32'hFFFFFFFE, 32'h2);
      watch;
      `CHK(n1, 24)
      `CHK(n2 > 0 && n2 < 24, 1'b1)
      `CHK(lamp[4], 1'b0)
      press(1, 1);
      `CHK(lamp, 32'h2)
      `CHK({lamp_bus, lamp_io}, 2'b00)
      press(0, 0);
      `CHK(lamp, 32'h4)
      press(1, 0);
      press(0, 0);
      press(0, 0);
      `CHK(lamp, 32'h80000000)
      press(1, 0);
      press(0, 0);
      `CHK(lamp, 32'h2)
      reg_wr(`REG_OUT_DATA, 32'h10A);
      press(0, 1);
      `CHK(lamp, 32'hA5)
      `CHK({lamp_bus, lamp_io}, 2'b01)
      press(1, 1);
      `CHK({lamp_bus, lamp_io}, 2'b10)
      cyc(70);
      `CHK(u_bus.out_img[1], 4'hA)
      reg_wr(`REG_CTRL, 32'h0);
      cyc(3);
      `CHK(bus_enable, 1'b1)
      cyc(140);
      `CHK({bus_enable, u_bus.out_img[1]}, 5'h00)
      rd_chk(`REG_STATUS, 32'h7, 32'h3);
      reg_wr(`REG_CTRL, 32'h1);
      cyc(140);
      reg_wr(`REG_FALLBACK, 32'h0);
      reg_wr(`REG_CTRL, 32'h0);
      cyc(140);
      `CHK({bus_enable, u_bus.out_img[1]}, 5'h0A)
      reg_wr(`REG_CTRL, 32'h3);
      u_bus.present[1] = 1'b0;
      cyc(140);
      `CHK(bus_enable, 1'b1)
      rd_chk(`REG_DETECTED, 32'hFFFFFFFE, 32'h8);
      u_bus.present[0] = 1'b1;
      cyc(200);
      `CHK(readdr_addr, 5'h01)
      rd_chk(`REG_ACTIVE, 32'hFFFFFFFE, 32'h2);
      u_bus.present[1] = 1'b0;
      cyc(140);
      u_bus.present[1] = 1'b1;
      cyc(140);
      rd_chk(`REG_ACTIVE, 32'hFFFFFFFE, 32'h2);
      u_bus.present[1] = 1'b0;
      cyc(140);
      u_bus.prof_ok[1] = 1'b0;
      u_bus.present[1] = 1'b1;
      cyc(140);
      rd_chk(`REG_STATUS, 32'h1000, 32'h1000);
      rd_chk(`REG_ACTIVE, 32'hFFFFFFFE, 32'h0);
      watch;
      `CHK(nq, 24)
      `CHK(ne > 0 && ne < 24, 1'b1)
      u_bus.tx_err = 1'b1;
      u_bus.prof_ok[1] = 1'b1;
      reg_wr(`REG_EXPECTED, 32'h6);
      rd_chk(`REG_STATUS, 32'h2000, 32'h2000);
      u_bus.tx_err = 1'b0;
      reg_wr(`REG_STATUS, 32'h8000);
      rd_chk(`REG_STATUS, 32'h2000, 32'h0);
      supply_fault <= 1'b1;
      cyc(10);
      `CHK({bus_enable, lamp_asi}, 2'b01)
      rd_chk(`REG_DETECTED, 32'hFFFFFFFE, 32'h0);
      supply_fault <= 1'b0;
      medium_cut <= 1'b1;
      cyc(10);
      `CHK(bus_enable, 1'b0)
      rd_chk(`REG_STATUS, 32'h800, 32'h800);
      medium_cut <= 1'b0;
      proc_link_lost <= 1'b1;
      cyc(10);
      `CHK(bus_enable, 1'b0)
      rd_chk(`REG_STATUS, 32'h7, 32'h4);
      proc_link_lost <= 1'b0;
      reg_wr(`REG_CTRL, 32'h5);
      cyc(6);
      `CHK(bus_enable, 1'b1)
      internal_fault <= 1'b1;
      cyc(6);
      `CHK({bus_enable, backplane_enable, lamp_err}, 3'b001)
      test_done;
   end
endmodule
